// *** logic/rim_irq_det.sv ***
`timescale 1ns/100ps

module rim_irq_det (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire rim_pkg::rim_irq_mode_t mode_i,
  input wire logic en_i,
  input wire logic cond_i,
  output logic irq_o
);
  import rim_pkg::*;

  logic cond_prev;
  logic next_irq;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cond_prev <= 1'b0;
    end else begin
      cond_prev <= cond_i;
    end
  end

  // Edge modes give a one-cycle flag; level mode follows the condition.
  always_comb begin
    unique case (mode_i)
      IRQ_RISE: next_irq = cond_i & ~cond_prev;
      IRQ_FALL: next_irq = ~cond_i & cond_prev;
      IRQ_LEVEL: next_irq = cond_i;
      IRQ_RSVD: next_irq = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= en_i & next_irq;
    end
  end

endmodule

// *** logic/rim_map.svh ***
`ifndef RIM_MAP_SVH
`define RIM_MAP_SVH

// Register offsets on the control port.
`define RIM_OFS_IRQ_MODE_TWO 8'h19
`define RIM_OFS_IRQ_MODE_THREE 8'h1a
`define RIM_OFS_PIN_ONE_SEL 8'h1b

// Field positions (least significant bit of each field).
`define RIM_CSCRC_MODE_LSB 6
`define RIM_PARITY_MODE_LSB 4
`define RIM_VALIDITY_MODE_LSB 2
`define RIM_BIPHASE_MODE_LSB 0
`define RIM_SLIP_MODE_LSB 0
`define RIM_PIN_SEL_LSB 0

// Field widths and writable masks.
`define RIM_MODE_W 2
`define RIM_SEL_W 4
`define RIM_MASK_MODE_THREE 8'h03
`define RIM_MASK_PIN_ONE_SEL 8'h0f

// Reset values.
`define RIM_RST_IRQ_MODE_TWO 8'h00
`define RIM_RST_IRQ_MODE_THREE 8'h00
`define RIM_RST_PIN_ONE_SEL 8'h00

// Answer to an unmapped read.
`define RIM_UNMAPPED_DATA 8'h00

`endif

// *** logic/rim_pin_mux.sv ***
`timescale 1ns/100ps

module rim_pin_mux #(
  parameter int SEL_W = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire rim_pkg::rim_pin_sel_t sel_i,
  input wire logic tx_irq_i,
  input wire logic rx_irq_i,
  input wire logic pre_emph_i,
  input wire logic non_audio_i,
  input wire logic non_valid_i,
  input wire logic chan_stat_i,
  input wire logic user_data_i,
  input wire logic block_start_i,
  input wire logic copy_i,
  input wire logic generation_i,
  input wire logic parity_err_i,
  input wire logic rx_sync_i,
  input wire logic tx_sync_i,
  output logic pin_o
);
  import rim_pkg::*;

  if (SEL_W != 4) begin : g_bad_sel_w
    $error("rim_pin_mux serves a four-bit selector only.");
  end

  logic next_pin;

  always_comb begin
    unique case (sel_i)
      PIN_LOW: next_pin = 1'b0;
      PIN_HIGH: next_pin = 1'b1;
      PIN_RSVD: next_pin = 1'b0;
      PIN_TX_IRQ: next_pin = ~tx_irq_i;
      PIN_RX_IRQ: next_pin = ~rx_irq_i;
      PIN_PRE_EMPH: next_pin = ~pre_emph_i;
      PIN_NON_AUDIO: next_pin = non_audio_i;
      PIN_NON_VALID: next_pin = non_valid_i;
      PIN_CHAN_STAT: next_pin = chan_stat_i;
      PIN_USER_DATA: next_pin = user_data_i;
      PIN_BLOCK_START: next_pin = block_start_i;
      PIN_COPY: next_pin = copy_i;
      PIN_GENERATION: next_pin = generation_i;
      PIN_PARITY_ERR: next_pin = parity_err_i;
      PIN_RX_SYNC: next_pin = rx_sync_i;
      PIN_TX_SYNC: next_pin = tx_sync_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_o <= 1'b0;
    end else begin
      pin_o <= next_pin;
    end
  end

endmodule

// *** logic/rim_pkg.sv ***
package rim_pkg;

  typedef enum logic [1:0] {
    IRQ_RISE = 2'b00,
    IRQ_FALL = 2'b01,
    IRQ_LEVEL = 2'b10,
    IRQ_RSVD = 2'b11
  } rim_irq_mode_t;

  typedef enum logic [3:0] {
    PIN_LOW = 4'b0000,
    PIN_HIGH = 4'b0001,
    PIN_RSVD = 4'b0010,
    PIN_TX_IRQ = 4'b0011,
    PIN_RX_IRQ = 4'b0100,
    PIN_PRE_EMPH = 4'b0101,
    PIN_NON_AUDIO = 4'b0110,
    PIN_NON_VALID = 4'b0111,
    PIN_CHAN_STAT = 4'b1000,
    PIN_USER_DATA = 4'b1001,
    PIN_BLOCK_START = 4'b1010,
    PIN_COPY = 4'b1011,
    PIN_GENERATION = 4'b1100,
    PIN_PARITY_ERR = 4'b1101,
    PIN_RX_SYNC = 4'b1110,
    PIN_TX_SYNC = 4'b1111
  } rim_pin_sel_t;

endpackage

// *** logic/rim_top.sv ***
`timescale 1ns/100ps
`include "rim_map.svh"

module rim_top (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic CS_CRC_ERR_I,
  input wire logic PARITY_ERR_I,
  input wire logic VALIDITY_ERR_I,
  input wire logic BIPHASE_ERR_I,
  input wire logic OUTPUT_SLIP_ERR_I,
  input wire logic OUTPUT_SLIP_IRQ_MASK_I,
  output logic CS_CRC_IRQ_O,
  output logic PARITY_IRQ_O,
  output logic VALIDITY_IRQ_O,
  output logic BIPHASE_IRQ_O,
  output logic OUTPUT_SLIP_IRQ_O,
  input wire logic AUDIO_TRANSMITTER_IRQ_I,
  input wire logic RX_IRQ_I,
  input wire logic PRE_EMPH_I,
  input wire logic NON_AUDIO_I,
  input wire logic NON_VALID_I,
  input wire logic CHAN_STATUS_BIT_I,
  input wire logic USER_DATA_BIT_I,
  input wire logic BLOCK_START_CLK_I,
  input wire logic COPY_BIT_I,
  input wire logic GENERATION_BIT_I,
  input wire logic RX_SYNC_CLK_I,
  input wire logic TX_SYNC_CLK_I,
  output logic OUTPUT_PIN_ONE_O,
  output rim_pkg::rim_pin_sel_t OUTPUT_PIN_ONE_SOURCE_SEL_O
);
  import rim_pkg::*;

  logic [7:0] irq_mode_two;
  logic [7:0] irq_mode_three;
  logic [7:0] pin_one_sel;
  rim_irq_mode_t chan_status_crc_irq_mode;
  rim_irq_mode_t parity_err_irq_mode;
  rim_irq_mode_t validity_err_irq_mode;
  rim_irq_mode_t biphase_err_irq_mode;
  rim_irq_mode_t output_slip_irq_mode;
  rim_pin_sel_t output_pin_one_source_sel;

  // Picks a two-bit mode field out of a mode register.
  function automatic rim_irq_mode_t mode_at(input logic [7:0] r, input int lsb);
    mode_at = rim_irq_mode_t'(r[lsb +: `RIM_MODE_W]);
  endfunction

  // Read value of each register; unused bits read back as zero.
  function automatic logic [7:0] read_value(input logic [7:0] addr, input logic [7:0] m2,
                                            input logic [7:0] m3, input logic [7:0] ps);
    case (addr)
      `RIM_OFS_IRQ_MODE_TWO: read_value = m2;
      `RIM_OFS_IRQ_MODE_THREE: read_value = m3 & `RIM_MASK_MODE_THREE;
      `RIM_OFS_PIN_ONE_SEL: read_value = ps & `RIM_MASK_PIN_ONE_SEL;
      default: read_value = `RIM_UNMAPPED_DATA;
    endcase
  endfunction

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      irq_mode_two <= `RIM_RST_IRQ_MODE_TWO;
    end else if (REG_WR_I && REG_ADDR_I == `RIM_OFS_IRQ_MODE_TWO) begin
      irq_mode_two <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      irq_mode_three <= `RIM_RST_IRQ_MODE_THREE;
    end else if (REG_WR_I && REG_ADDR_I == `RIM_OFS_IRQ_MODE_THREE) begin
      irq_mode_three <= REG_WDATA_I & `RIM_MASK_MODE_THREE;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      pin_one_sel <= `RIM_RST_PIN_ONE_SEL;
    end else if (REG_WR_I && REG_ADDR_I == `RIM_OFS_PIN_ONE_SEL) begin
      pin_one_sel <= REG_WDATA_I & `RIM_MASK_PIN_ONE_SEL;
    end
  end

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O <= 8'h00;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= read_value(REG_ADDR_I, irq_mode_two, irq_mode_three, pin_one_sel);
      end
    end
  end

  assign chan_status_crc_irq_mode = mode_at(irq_mode_two, `RIM_CSCRC_MODE_LSB);
  assign parity_err_irq_mode = mode_at(irq_mode_two, `RIM_PARITY_MODE_LSB);
  assign validity_err_irq_mode = mode_at(irq_mode_two, `RIM_VALIDITY_MODE_LSB);
  assign biphase_err_irq_mode = mode_at(irq_mode_two, `RIM_BIPHASE_MODE_LSB);
  assign output_slip_irq_mode = mode_at(irq_mode_three, `RIM_SLIP_MODE_LSB);
  assign output_pin_one_source_sel =
    rim_pin_sel_t'(pin_one_sel[`RIM_PIN_SEL_LSB +: `RIM_SEL_W]);
  assign OUTPUT_PIN_ONE_SOURCE_SEL_O = output_pin_one_source_sel;

  rim_irq_det u_cs_crc_det (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .mode_i(chan_status_crc_irq_mode),
    .en_i(1'b1),
    .cond_i(CS_CRC_ERR_I),
    .irq_o(CS_CRC_IRQ_O)
  );

  rim_irq_det u_parity_det (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .mode_i(parity_err_irq_mode),
    .en_i(1'b1),
    .cond_i(PARITY_ERR_I),
    .irq_o(PARITY_IRQ_O)
  );

  rim_irq_det u_validity_det (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .mode_i(validity_err_irq_mode),
    .en_i(1'b1),
    .cond_i(VALIDITY_ERR_I),
    .irq_o(VALIDITY_IRQ_O)
  );

  rim_irq_det u_biphase_det (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .mode_i(biphase_err_irq_mode),
    .en_i(1'b1),
    .cond_i(BIPHASE_ERR_I),
    .irq_o(BIPHASE_IRQ_O)
  );

  // The slip detector keeps tracking edges while masked, so unmasking
  // does not invent a transition that happened earlier.
  rim_irq_det u_slip_det (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .mode_i(output_slip_irq_mode),
    .en_i(OUTPUT_SLIP_IRQ_MASK_I),
    .cond_i(OUTPUT_SLIP_ERR_I),
    .irq_o(OUTPUT_SLIP_IRQ_O)
  );

  rim_pin_mux #(
    .SEL_W(`RIM_SEL_W)
  ) u_pin_mux (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .sel_i(output_pin_one_source_sel),
    .tx_irq_i(AUDIO_TRANSMITTER_IRQ_I),
    .rx_irq_i(RX_IRQ_I),
    .pre_emph_i(PRE_EMPH_I),
    .non_audio_i(NON_AUDIO_I),
    .non_valid_i(NON_VALID_I),
    .chan_stat_i(CHAN_STATUS_BIT_I),
    .user_data_i(USER_DATA_BIT_I),
    .block_start_i(BLOCK_START_CLK_I),
    .copy_i(COPY_BIT_I),
    .generation_i(GENERATION_BIT_I),
    .parity_err_i(PARITY_ERR_I),
    .rx_sync_i(RX_SYNC_CLK_I),
    .tx_sync_i(TX_SYNC_CLK_I),
    .pin_o(OUTPUT_PIN_ONE_O)
  );

  default clocking cb @(posedge CLK_SYS_I);
  endclocking

  default disable iff (!RST_B_I);

  sequence s_sel_write(logic [3:0] v);
    REG_WR_I && REG_ADDR_I == `RIM_OFS_PIN_ONE_SEL && REG_WDATA_I[3:0] == v;
  endsequence

  sequence s_no_sel_write;
    !(REG_WR_I && REG_ADDR_I == `RIM_OFS_PIN_ONE_SEL);
  endsequence

  sequence s_mode_two_write;
    REG_WR_I && REG_ADDR_I == `RIM_OFS_IRQ_MODE_TWO;
  endsequence

  // The mode must still be rising one cycle later, else a new mode may flag legally.
  sequence s_crc_rose_held;
    chan_status_crc_irq_mode == IRQ_RISE && $rose(CS_CRC_ERR_I)
      ##1 chan_status_crc_irq_mode == IRQ_RISE;
  endsequence

  AST_MODE_TWO_STORE: assert property (
    s_mode_two_write |=> irq_mode_two == $past(REG_WDATA_I)
  ) else $error("Mode register two did not take the written value.");

  AST_MODE_TWO_READ: assert property (
    s_mode_two_write ##1 (REG_RD_I && REG_ADDR_I == `RIM_OFS_IRQ_MODE_TWO)
      |=> REG_RDATA_O == $past(REG_WDATA_I, 2) && REG_RVALID_O
  ) else $error("Mode register two read back a wrong value.");

  AST_MODE_THREE_ZERO: assert property (
    REG_RD_I && REG_ADDR_I == `RIM_OFS_IRQ_MODE_THREE |=> REG_RDATA_O[7:2] == 6'h00
  ) else $error("Mode register three upper bits did not read zero.");

  AST_PIN_SEL_ZERO: assert property (
    REG_RD_I && REG_ADDR_I == `RIM_OFS_PIN_ONE_SEL |=> REG_RDATA_O[7:4] == 4'h0
  ) else $error("Pin select upper bits did not read zero.");

  AST_CRC_RISE: assert property (
    s_crc_rose_held |-> CS_CRC_IRQ_O ##1 !CS_CRC_IRQ_O
  ) else $error("CRC rising edge did not give a one-cycle interrupt.");

  AST_CRC_RSVD: assert property (
    chan_status_crc_irq_mode == IRQ_RSVD |=> !CS_CRC_IRQ_O
  ) else $error("Reserved mode produced a CRC interrupt.");

  AST_PARITY_FALL: assert property (
    parity_err_irq_mode == IRQ_FALL && $fell(PARITY_ERR_I) |=> PARITY_IRQ_O
  ) else $error("Parity falling edge gave no interrupt.");

  AST_PARITY_NO_RISE: assert property (
    parity_err_irq_mode == IRQ_FALL && PARITY_ERR_I |=> !PARITY_IRQ_O
  ) else $error("Parity interrupt fired in falling mode while error was high.");

  AST_VALIDITY_LEVEL: assert property (
    validity_err_irq_mode == IRQ_LEVEL |=> VALIDITY_IRQ_O == $past(VALIDITY_ERR_I)
  ) else $error("Validity level interrupt did not follow its condition.");

  AST_BIPHASE_HELD: assert property (
    biphase_err_irq_mode == IRQ_RISE && BIPHASE_ERR_I [*2] |=> !BIPHASE_IRQ_O
  ) else $error("Biphase rising mode flagged a steady condition.");

  AST_SLIP_MASKED: assert property (
    !OUTPUT_SLIP_IRQ_MASK_I |=> !OUTPUT_SLIP_IRQ_O
  ) else $error("Masked slip interrupt reached the output.");

  AST_SLIP_LEVEL: assert property (
    OUTPUT_SLIP_IRQ_MASK_I && output_slip_irq_mode == IRQ_LEVEL && OUTPUT_SLIP_ERR_I
      |=> OUTPUT_SLIP_IRQ_O
  ) else $error("Enabled slip level interrupt missing.");

  AST_PIN_LOW: assert property (
    output_pin_one_source_sel == PIN_LOW |=> !OUTPUT_PIN_ONE_O
  ) else $error("Pin one not low for selector zero.");

  AST_PIN_HIGH: assert property (
    s_sel_write(4'h1) ##1 s_no_sel_write |=> OUTPUT_PIN_ONE_O
  ) else $error("Pin one not high after selecting forced high.");

  AST_PIN_RX_IRQ: assert property (
    s_sel_write(4'h4) ##1 s_no_sel_write |=> OUTPUT_PIN_ONE_O == !$past(RX_IRQ_I)
  ) else $error("Pin one does not show the receiver interrupt active low.");

  AST_PIN_PRE_EMPH: assert property (
    output_pin_one_source_sel == PIN_PRE_EMPH |=> OUTPUT_PIN_ONE_O == !$past(PRE_EMPH_I)
  ) else $error("Pin one does not show pre-emphasis active low.");

  AST_PIN_BLOCK: assert property (
    output_pin_one_source_sel == PIN_BLOCK_START
      |=> OUTPUT_PIN_ONE_O == $past(BLOCK_START_CLK_I)
  ) else $error("Pin one does not follow the block start clock.");

  AST_PIN_COPY: assert property (
    output_pin_one_source_sel == PIN_COPY |=> OUTPUT_PIN_ONE_O == $past(COPY_BIT_I)
  ) else $error("Pin one does not follow the copy bit.");

  AST_PIN_GEN: assert property (
    output_pin_one_source_sel == PIN_GENERATION
      |=> OUTPUT_PIN_ONE_O == $past(GENERATION_BIT_I)
  ) else $error("Pin one does not follow the generation bit.");

  AST_PIN_TX_SYNC: assert property (
    output_pin_one_source_sel == PIN_TX_SYNC |=> OUTPUT_PIN_ONE_O == $past(TX_SYNC_CLK_I)
  ) else $error("Pin one does not follow the transmitter sync clock.");

endmodule

// *** sim/rim_host.sv ***
`timescale 1ns/100ps
module rim_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Tasks start just after a rising edge and end after an idle edge; idle lines show inverses.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask
  // A write followed at the very next edge by a read of the same offset.
  task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
                           output logic v);
    addr_o <= a;
    wdata_o <= wd;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~wd;
    #1;
    d = rdata_i;
    v = rvalid_i;
    @(posedge clk_i);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
    v = rvalid_i;
    @(posedge clk_i);
  endtask
endmodule

// *** sim/tb_rim_top.sv ***
`timescale 1ns/100ps
`include "rim_map.svh"
module tb_rim_top;
  import rim_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic chk_on = 1'b1;
  logic run = 1'b0;
  logic mask = 1'b0;
  logic [4:0] errs = 5'h00;
  logic [4:0] prv = 5'h00;
  logic [11:0] srcs = 12'h000;
  logic [7:0] sh_m2 = 8'h00;
  logic [7:0] sh_m3 = 8'h00;
  logic [7:0] sh_ps = 8'h00;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid, v, pin;
  logic [4:0] irq;
  rim_pin_sel_t sel_o;
  int errors = 0;
  int cmp_count = 0;

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  rim_host host (.clk_i(clk_sys), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  rim_top uut (.CLK_SYS_I(clk_sys), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .BIPHASE_ERR_I(errs[0]), .VALIDITY_ERR_I(errs[1]), .PARITY_ERR_I(errs[2]),
    .CS_CRC_ERR_I(errs[3]), .OUTPUT_SLIP_ERR_I(errs[4]), .OUTPUT_SLIP_IRQ_MASK_I(mask),
    .BIPHASE_IRQ_O(irq[0]), .VALIDITY_IRQ_O(irq[1]), .PARITY_IRQ_O(irq[2]),
    .CS_CRC_IRQ_O(irq[3]), .OUTPUT_SLIP_IRQ_O(irq[4]),
    .AUDIO_TRANSMITTER_IRQ_I(srcs[0]), .RX_IRQ_I(srcs[1]), .PRE_EMPH_I(srcs[2]),
    .NON_AUDIO_I(srcs[3]), .NON_VALID_I(srcs[4]), .CHAN_STATUS_BIT_I(srcs[5]),
    .USER_DATA_BIT_I(srcs[6]), .BLOCK_START_CLK_I(srcs[7]), .COPY_BIT_I(srcs[8]),
    .GENERATION_BIT_I(srcs[9]), .RX_SYNC_CLK_I(srcs[10]), .TX_SYNC_CLK_I(srcs[11]),
    .OUTPUT_PIN_ONE_O(pin), .OUTPUT_PIN_ONE_SOURCE_SEL_O(sel_o));

  function automatic logic irq_f(logic [1:0] m, logic c, logic p);
    case (m)
      2'b00: return c & ~p;
      2'b01: return ~c & p;
      2'b10: return c;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic pin_f(logic [3:0] s, logic [11:0] x, logic par);
    case (s)
      4'h0, 4'h2: return 1'b0;
      4'h1: return 1'b1;
      4'h3, 4'h4, 4'h5: return ~x[s - 4'h3];
      4'hd: return par;
      4'he, 4'hf: return x[s - 4'h4];
      default: return x[s - 4'h3];
    endcase
  endfunction

  // Random settings stay clear of the reserved mode code.
  function automatic logic [7:0] no_rsvd(logic [7:0] m);
    for (int k = 0; k < 8; k += 2) begin
      if (m[k +: 2] == 2'b11) begin
        m[k +: 2] = 2'b10;
      end
    end
    return m;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.rd_reg(a, d, v);
    check("rvalid", 8'(v), 8'h01);
    check("rdata", d, e);
  endtask

  // Monitoring is paused while the shadow copy of the registers is being brought up to date.
  task automatic set_cfg(input logic [7:0] m2, input logic [7:0] m3, input logic [7:0] ps);
    logic [7:0] ua;
    ua = 8'h1c + 8'($urandom_range(0, 200));
    chk_on = 1'b0;
    host.wr_rd_reg(`RIM_OFS_IRQ_MODE_TWO, m2, d, v);
    check("rvalid_b2b", 8'(v), 8'h01);
    check("rdata_b2b", d, m2);
    host.wr_reg(`RIM_OFS_IRQ_MODE_THREE, m3);
    host.wr_reg(`RIM_OFS_PIN_ONE_SEL, ps);
    host.wr_reg(ua, ~m2);
    sh_m2 = m2;
    sh_m3 = m3 & 8'h03;
    sh_ps = ps & 8'h0f;
    rd_chk(`RIM_OFS_IRQ_MODE_TWO, sh_m2);
    rd_chk(`RIM_OFS_IRQ_MODE_THREE, sh_m3);
    rd_chk(`RIM_OFS_PIN_ONE_SEL, sh_ps);
    rd_chk(ua, 8'h00);
    check("pin_sel", 8'(sel_o), sh_ps);
    chk_on = 1'b1;
  endtask

  always @(posedge clk_sys) begin
    if (run) begin
      errs <= 5'($urandom);
      srcs <= 12'($urandom);
      mask <= 1'($urandom);
    end
  end

  // Samples what the design sees at the edge, then compares once its updates have landed.
  always @(posedge clk_sys) begin : mon
    logic [4:0] c, p, ex;
    logic [9:0] md;
    logic r, mk, ep;
    c = errs;
    p = prv;
    r = rst_b;
    mk = mask;
    md = {sh_m3[1:0], sh_m2};
    prv <= r ? c : 5'h00;
    ep = r & pin_f(sh_ps[3:0], srcs, c[2]);
    #1;
    for (int i = 0; i < 5; i++) begin
      ex[i] = r & irq_f(md[2*i +: 2], c[i], p[i]);
    end
    ex[4] = ex[4] & mk;
    if (chk_on) begin
      check("irq_biphase", 8'(irq[0]), 8'(ex[0]));
      check("irq_validity", 8'(irq[1]), 8'(ex[1]));
      check("irq_parity", 8'(irq[2]), 8'(ex[2]));
      check("irq_crc", 8'(irq[3]), 8'(ex[3]));
      check("irq_slip", 8'(irq[4]), 8'(ex[4]));
      check("pin_one", 8'(pin), 8'(ep));
    end
  end

  initial begin
    logic [7:0] m2, m3, ps;
    void'($urandom(32'h33b1));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    run <= 1'b1;
    rd_chk(`RIM_OFS_IRQ_MODE_TWO, 8'h00);
    rd_chk(`RIM_OFS_IRQ_MODE_THREE, 8'h00);
    rd_chk(`RIM_OFS_PIN_ONE_SEL, 8'h00);
    for (int i = 0; i < 36; i++) begin
      if (i == 20) begin
        rst_b <= 1'b0;
        @(posedge clk_sys);
        sh_m2 = 8'h00;
        sh_m3 = 8'h00;
        sh_ps = 8'h00;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_chk(`RIM_OFS_IRQ_MODE_TWO, 8'h00);
      end
      // Hand-written corner cases probe the reserved codes; random settings avoid them.
      m2 = (i < 4) ? {4{2'(i)}} : no_rsvd(8'($urandom));
      m3 = (i < 4) ? 8'(i) : no_rsvd(8'($urandom));
      ps = (i < 16) ? 8'(i) : 8'($urandom);
      if (i >= 16 && ps[3:0] == 4'h2) begin
        ps[1] = 1'b0;
      end
      set_cfg(m2, m3, ps);
      repeat (60) @(posedge clk_sys);
    end
    test_done();
  end

  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule
